// [bench/amau_core_test.sv]
// self-checking bench for the accumulator move and arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module amau_core_test;
  import amau_pkg::*;
  logic ref_clk, rst_n, op_valid, sp_load; // driven inputs
  amau_op_t op_code; // operation offered
  logic [7:0] op_imm, op_addr, sp_value; // operands
  logic [7:0] mem_addr, mem_wdata, mem_rdata, acc, stack_pointer; // observed
  logic op_ready, op_done, mem_we, mem_re; // handshake and strobes
  logic zero_flag, carry_flag, half_carry_flag, signed_excess_flag; // flags
  wire logic [3:0] flags; // flags packed as in the stack pair
  int fail_count, total_checks; // report counters
  logic [7:0] m_acc, m_sp; // expected accumulator and stack pointer
  logic [3:0] m_fl; // expected flags
  assign flags = {signed_excess_flag, half_carry_flag, carry_flag, zero_flag};
  amau_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .op_addr(op_addr), .op_ready(op_ready),
    .op_done(op_done), .sp_load(sp_load), .sp_value(sp_value), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
    .acc(acc), .stack_pointer(stack_pointer), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .signed_excess_flag(signed_excess_flag));
  amau_ram u_ram (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
  // ---------------------------------------------------------------
  // clock and helpers
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // byte compare, counted
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reference add or subtract: {ov, ac, c, z, result}
  function automatic logic [11:0] calc(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci, input logic sb);
    int u; // unsigned result, a borrow shows as negative
    int h; // low nibble result
    int s; // signed result
    int k; // sign of the second operand: +1 add, -1 subtract
    k = sb ? -1 : 1;
    u = int'(a) + k * int'(b) + k * int'(ci);
    h = int'(a[3:0]) + k * int'(b[3:0]) + k * int'(ci);
    s = int'($signed(a)) + k * int'($signed(b)) + k * int'(ci);
    calc = {(s < -128) || (s > 127), (h < 0) || (h > 15), (u < 0) || (u > 255),
            u[7:0] == 8'h00, u[7:0]};
  endfunction
  // final verdict
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // run one operation, predict its effect and compare all results
  task automatic do_op(input amau_op_t op, input logic [7:0] imm, input logic [7:0] addr);
    logic [11:0] r;
    logic [7:0] m, ea, ev;
    logic tomem;
    int n, lat;
    m = u_ram.mem[addr];
    ea = addr;
    ev = m;
    tomem = 1'b0;
    r = {m_fl, m_acc};
    lat = (op == OP_ADD_AI || op == OP_ADDC_A || op == OP_SUB_AI) ? 1 : (op == OP_POP) ? 3 : 2;
    case (op)
      OP_ADD_AI: r = calc(m_acc, imm, 1'b0, 1'b0);
      OP_ADD_AM: r = calc(m_acc, m, 1'b0, 1'b0);
      OP_ADD_MA: begin r = calc(m_acc, m, 1'b0, 1'b0); tomem = 1'b1; end
      OP_ADDC_AM: r = calc(m_acc, m, m_fl[1], 1'b0);
      OP_ADDC_MA: begin r = calc(m_acc, m, m_fl[1], 1'b0); tomem = 1'b1; end
      OP_ADDC_A: r = calc(m_acc, 8'h00, m_fl[1], 1'b0);
      OP_ADDC_M: begin r = calc(m, 8'h00, m_fl[1], 1'b0); tomem = 1'b1; end
      OP_SUB_AI: r = calc(m_acc, imm, 1'b0, 1'b1);
      OP_SUB_AM: r = calc(m_acc, m, 1'b0, 1'b1);
      OP_SUB_MA: begin r = calc(m, m_acc, 1'b0, 1'b1); tomem = 1'b1; end
      OP_SUBC_AM: r = calc(m_acc, m, m_fl[1], 1'b1);
      OP_XCH: begin ev = m_acc; r[7:0] = m; end
      OP_STORE_IND: begin ea = u_ram.mem[addr & 8'h1f]; ev = m_acc; end
      OP_PUSH: begin ea = m_sp; ev = m_acc; m_sp = m_sp + 8'h02; end
      OP_POP: begin m_sp = m_sp - 8'h02; r = {u_ram.mem[m_sp + 8'h01][3:0], u_ram.mem[m_sp]}; end
      default: ;
    endcase
    if (tomem) begin
      ev = r[7:0];
      r[7:0] = m_acc;
    end
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_imm <= imm;
    op_addr <= addr;
    n = 0;
    // bounded wait for the completion pulse, looked at mid-cycle while it stands
    do begin
      @(negedge ref_clk);
      n++;
    end while (op_done !== 1'b1 && n < 20);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
    @(negedge ref_clk);
    m_acc = r[7:0];
    m_fl = r[11:8];
    chk8(8'(n), 8'(lat));
    chk8(acc, m_acc);
    chk8({4'h0, flags}, {4'h0, m_fl});
    chk8(stack_pointer, m_sp);
    chk8(u_ram.mem[ea], ev);
    chk8({4'h0, op_ready, op_done, mem_we, mem_re}, 8'h08);
    if (op == OP_PUSH) begin
      chk8(u_ram.mem[m_sp - 8'h01], {4'h0, m_fl});
    end
  endtask
  // load the accumulator through an exchange, flags kept
  task automatic set_acc(input logic [7:0] v);
    u_ram.mem[8'hf0] = v;
    do_op(OP_XCH, 8'h00, 8'hf0);
  endtask
  // force the carry flag by a known addition
  task automatic set_c(input logic c);
    set_acc(c ? 8'hff : 8'h00);
    do_op(OP_ADD_AI, c ? 8'h01 : 8'h00, 8'h00);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk8(acc, ACC_RESET);
    chk8(stack_pointer, SP_RESET);
    chk8({4'h0, flags}, 8'h00);
    chk8({4'h0, op_ready, op_done, mem_we, mem_re}, 8'h08);
    $display("test reset done");
  endtask
  task automatic t_store;
    u_ram.mem[8'h03] = 8'h5b;
    u_ram.mem[8'h04] = 8'h00;
    set_acc(8'h80);
    do_op(OP_ADD_AI, 8'h80, 8'h00);
    set_acc(8'ha5);
    do_op(OP_STORE_IND, 8'h00, 8'h23);
    u_ram.mem[8'h50] = 8'h3c;
    do_op(OP_XCH, 8'h00, 8'h50);
    $display("test store and exchange done");
  endtask
  task automatic t_arith;
    amau_op_t ops [11] = '{OP_ADD_AI, OP_ADD_AM, OP_ADD_MA, OP_ADDC_AM, OP_ADDC_MA,
      OP_ADDC_A, OP_ADDC_M, OP_SUB_AI, OP_SUB_AM, OP_SUB_MA, OP_SUBC_AM};
    logic [7:0] av [4] = '{8'h71, 8'h80, 8'h05, 8'h7f};
    logic [7:0] mv [4] = '{8'h8f, 8'h01, 8'h0b, 8'hff};
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 8; j++) begin
        set_c(j[0]);
        set_acc(av[j / 2]);
        u_ram.mem[8'h60] = mv[j / 2];
        do_op(ops[i], mv[j / 2], 8'h60);
      end
    end
    $display("test arithmetic done"); // above
  endtask
  task automatic t_stack;
    @(posedge ref_clk);
    sp_load <= 1'b1;
    sp_value <= 8'h30;
    @(posedge ref_clk);
    sp_load <= 1'b0;
    @(negedge ref_clk);
    m_sp = 8'h30;
    chk8(stack_pointer, 8'h30);
    set_c(1'b1);
    set_acc(8'h3c);
    do_op(OP_PUSH, 8'h00, 8'h60);
    set_c(1'b0);
    do_op(OP_PUSH, 8'h00, 8'h60);
    set_acc(8'h11);
    do_op(OP_POP, 8'h00, 8'h60);
    do_op(OP_POP, 8'h00, 8'h60);
    $display("test stack done");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_imm = 8'h00;
    op_addr = 8'h00;
    sp_load = 1'b0;
    sp_value = 8'h00;
    fail_count = 0;
    total_checks = 0;
    m_acc = ACC_RESET;
    m_sp = SP_RESET;
    m_fl = 4'h0;
    // known contents everywhere, so a stray write cannot hide behind unknowns
    for (int i = 0; i < 256; i++) begin
      u_ram.mem[i] = 8'h00;
    end
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_store();
    t_arith();
    t_stack();
    conclude();
  end
endmodule
`default_nettype wire

// [bench/amau_ram.sv]
// data memory model on the far side of the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module amau_ram (
  input wire logic ref_clk,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:255]; // byte store, preloaded by the bench
  // ---------------------------------------------------------------
  // registered port
  // ---------------------------------------------------------------
  initial mem_rdata = 8'h00;
  // read data stand one cycle; otherwise the line toggles so stale data never match
  always @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_re) begin
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// [pkg/amau_pkg.sv]
// constants and types shared by the accumulator move and arithmetic unit
package amau_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;  // data byte width
  localparam int ADDR_W = 8;  // data memory address width

  // ---------------------------------------------------------------
  // flag byte layout as stored by save and restore
  // ---------------------------------------------------------------
  localparam int FLAG_Z_BIT = 0;   // zero flag position
  localparam int FLAG_C_BIT = 1;   // carry flag position
  localparam int FLAG_AC_BIT = 2;  // half carry flag position
  localparam int FLAG_OV_BIT = 3;  // signed excess flag position

  // ---------------------------------------------------------------
  // reset values and address constants
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;        // accumulator after reset
  localparam logic [7:0] SP_RESET = 8'h00;         // stack pointer after reset
  localparam logic FLAG_RESET = 1'b0;              // each flag after reset
  localparam logic [7:0] SP_STEP = 8'h02;          // stack pointer step per pair
  localparam logic [7:0] PAIR_HI_OFS = 8'h01;      // flag byte sits one above acc
  localparam logic [7:0] PTR_AREA_MASK = 8'h1f;    // pointers live in 0..31 only
  localparam logic [7:0] ZERO_BYTE = 8'h00;        // zero operand

  // ---------------------------------------------------------------
  // operation codes given by the decoder
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,        // nothing
    OP_STORE_IND = 4'h1,  // [pointer] <- acc
    OP_XCH = 4'h2,        // swap acc and memory
    OP_PUSH = 4'h3,       // save acc and flags at stack pointer
    OP_POP = 4'h4,        // restore acc and flags
    OP_ADD_AI = 4'h5,     // acc <- acc + imm
    OP_ADD_AM = 4'h6,     // acc <- acc + mem
    OP_ADD_MA = 4'h7,     // mem <- acc + mem
    OP_ADDC_AM = 4'h8,    // acc <- acc + mem + c
    OP_ADDC_MA = 4'h9,    // mem <- acc + mem + c
    OP_ADDC_A = 4'ha,     // acc <- acc + c
    OP_ADDC_M = 4'hb,     // mem <- mem + c
    OP_SUB_AI = 4'hc,     // acc <- acc - imm
    OP_SUB_AM = 4'hd,     // acc <- acc - mem
    OP_SUB_MA = 4'he,     // mem <- mem - acc
    OP_SUBC_AM = 4'hf     // acc <- acc - mem - c
  } amau_op_t;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,   // ready for an operation
    ST_PTR = 6'b000010,    // pointer byte on read data
    ST_OPER = 6'b000100,   // memory operand on read data
    ST_PUSH2 = 6'b001000,  // writing flag byte of the pair
    ST_POP1 = 6'b010000,   // accumulator byte on read data
    ST_POP2 = 6'b100000    // flag byte on read data
  } amau_state_t;

endpackage

// [src/amau_core.sv]
// execution datapath: indirect store, exchange, save/restore, add and subtract
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module amau_core (
  input wire logic ref_clk,                 // system clock, 40 MHz
  input wire logic rst_n,                   // asynchronous reset, active low
  input wire logic op_valid,                // decoder offers an operation
  input wire amau_pkg::amau_op_t op_code,   // operation offered
  input wire logic [7:0] op_imm,            // immediate operand
  input wire logic [7:0] op_addr,           // memory operand or pointer address
  output logic op_ready,                    // unit can take an operation
  output logic op_done,                     // last cycle of an operation
  input wire logic sp_load,                 // load stack pointer from sp_value while idle and no operation is taken
  input wire logic [7:0] sp_value,          // new stack pointer
  output logic [7:0] mem_addr,              // data memory address
  output logic [7:0] mem_wdata,             // data memory write data
  output logic mem_we,                      // data memory write strobe
  output logic mem_re,                      // data memory read strobe
  input wire logic [7:0] mem_rdata,         // read data, one cycle after mem_re
  output logic [7:0] acc,                   // accumulator
  output logic [7:0] stack_pointer,         // stack pointer
  output logic zero_flag,                   // result was zero
  output logic carry_flag,                  // carry out or borrow
  output logic half_carry_flag,             // low nibble carry
  output logic signed_excess_flag           // signed overflow
);
  import amau_pkg::*;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // add or subtract with carry in or borrow in; returns {ov, ac, c, z, result}
  function automatic logic [11:0] alu_calc(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
    logic [7:0] bb;
    logic ci;
    logic [8:0] full;
    logic [4:0] low;
    logic co;
    logic hc;
    logic ov;
    bb = sub ? ~b : b;           // two's complement: invert and add one
    ci = sub ? ~cin : cin;       // borrow in becomes missing plus one
    full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    co = sub ? ~full[8] : full[8];
    hc = sub ? ~low[4] : low[4];
    ov = (a[7] == bb[7]) && (full[7] != a[7]);
    alu_calc = {ov, hc, co, (full[7:0] == 8'h00), full[7:0]};
  endfunction

  // operation that needs one byte read from memory first
  function automatic logic needs_mem(input amau_op_t op);
    needs_mem = (op == OP_XCH) || (op == OP_ADD_AM) || (op == OP_ADD_MA) ||
                (op == OP_ADDC_AM) || (op == OP_ADDC_MA) || (op == OP_ADDC_M) ||
                (op == OP_SUB_AM) || (op == OP_SUB_MA) || (op == OP_SUBC_AM);
  endfunction

  // operation that completes in its first cycle
  function automatic logic is_single(input amau_op_t op);
    is_single = (op == OP_ADD_AI) || (op == OP_ADDC_A) || (op == OP_SUB_AI);
  endfunction

  // ---------------------------------------------------------------
  // internal signals
  // ---------------------------------------------------------------
  amau_state_t state;          // sequencer state
  amau_state_t next_state;     // sequencer state next cycle
  amau_op_t op_q;              // operation held while it runs
  logic [7:0] addr_q;          // memory operand address held
  logic op_fire;               // operation taken this cycle
  amau_op_t cur_op;            // operation whose arithmetic is live
  logic [7:0] opa;             // first alu operand
  logic [7:0] opb;             // second alu operand
  logic alu_cin;               // carry or borrow into the alu
  logic alu_sub;               // alu subtracts
  logic to_mem;                // result goes back to memory
  logic [11:0] alu_out;        // alu result with flags
  logic arith_go;              // arithmetic result lands this cycle
  logic [7:0] flag_byte;       // flags packed for a save

  assign op_ready = (state == ST_IDLE);
  assign op_fire = op_ready && op_valid && (op_code != OP_NOP);
  assign cur_op = (state == ST_IDLE) ? op_code : op_q;
  assign arith_go = (op_fire && is_single(op_code)) ||
                    ((state == ST_OPER) && (op_q != OP_XCH));
  assign alu_out = alu_calc(opa, opb, alu_cin, alu_sub);

  // pack flags for the stack pair
  always_comb begin
    flag_byte = 8'h00;
    flag_byte[FLAG_Z_BIT] = zero_flag;
    flag_byte[FLAG_C_BIT] = carry_flag;
    flag_byte[FLAG_AC_BIT] = half_carry_flag;
    flag_byte[FLAG_OV_BIT] = signed_excess_flag;
  end

  // ---------------------------------------------------------------
  // operand selection
  // ---------------------------------------------------------------

  // choose alu operands and destination from the live operation
  always_comb begin
    opa = acc;
    opb = ZERO_BYTE;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    to_mem = 1'b0;
    unique case (cur_op)
      OP_ADD_AI: begin
        opb = op_imm;
      end
      OP_ADD_AM: begin
        opb = mem_rdata;
      end
      OP_ADD_MA: begin
        opb = mem_rdata;
        to_mem = 1'b1;
      end
      OP_ADDC_AM: begin
        opb = mem_rdata;
        alu_cin = carry_flag;
      end
      OP_ADDC_MA: begin
        opb = mem_rdata;
        alu_cin = carry_flag;
        to_mem = 1'b1;
      end
      OP_ADDC_A: begin
        alu_cin = carry_flag;
      end
      OP_ADDC_M: begin
        opa = mem_rdata;
        alu_cin = carry_flag;
        to_mem = 1'b1;
      end
      OP_SUB_AI: begin
        opb = op_imm;
        alu_sub = 1'b1;
      end
      OP_SUB_AM: begin
        opb = mem_rdata;
        alu_sub = 1'b1;
      end
      OP_SUB_MA: begin
        opa = mem_rdata;
        opb = acc;
        alu_sub = 1'b1;
        to_mem = 1'b1;
      end
      OP_SUBC_AM: begin
        opb = mem_rdata;
        alu_sub = 1'b1;
        alu_cin = carry_flag;
      end
      default: begin
        opa = acc;  // moves use no alu
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------

  // next state and done strobe
  always_comb begin
    next_state = state;
    op_done = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (op_fire) begin
          if (op_code == OP_STORE_IND) begin
            next_state = ST_PTR;
          end else if (needs_mem(op_code)) begin
            next_state = ST_OPER;
          end else if (op_code == OP_PUSH) begin
            next_state = ST_PUSH2;
          end else if (op_code == OP_POP) begin
            next_state = ST_POP1;
          end else begin
            op_done = 1'b1;  // immediate and carry-only acc ops
          end
        end
      end
      ST_PTR: begin
        next_state = ST_IDLE;
        op_done = 1'b1;
      end
      ST_OPER: begin
        next_state = ST_IDLE;
        op_done = 1'b1;
      end
      ST_PUSH2: begin
        next_state = ST_IDLE;
        op_done = 1'b1;
      end
      ST_POP1: begin
        next_state = ST_POP2;
      end
      ST_POP2: begin
        next_state = ST_IDLE;
        op_done = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // hold the operation and its address while it runs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= OP_NOP;
      addr_q <= 8'h00;
    end else if (op_fire) begin
      op_q <= op_code;
      addr_q <= op_addr;
    end
  end

  // ---------------------------------------------------------------
  // data memory port
  // ---------------------------------------------------------------

  // strobes, address and write data per state
  always_comb begin
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
    unique case (state)
      ST_IDLE: begin
        if (op_fire && (op_code == OP_STORE_IND)) begin
          mem_re = 1'b1;
          mem_addr = op_addr & PTR_AREA_MASK;
        end else if (op_fire && needs_mem(op_code)) begin
          mem_re = 1'b1;
          mem_addr = op_addr;
        end else if (op_fire && (op_code == OP_PUSH)) begin
          mem_we = 1'b1;
          mem_addr = stack_pointer;
          mem_wdata = acc;
        end else if (op_fire && (op_code == OP_POP)) begin
          mem_re = 1'b1;
          mem_addr = stack_pointer - SP_STEP;
        end
      end
      ST_PTR: begin
        mem_we = 1'b1;
        mem_addr = mem_rdata;
        mem_wdata = acc;
      end
      ST_OPER: begin
        if (op_q == OP_XCH) begin
          mem_we = 1'b1;
          mem_addr = addr_q;
          mem_wdata = acc;
        end else if (to_mem) begin
          mem_we = 1'b1;
          mem_addr = addr_q;
          mem_wdata = alu_out[7:0];
        end
      end
      ST_PUSH2: begin
        mem_we = 1'b1;
        mem_addr = stack_pointer + PAIR_HI_OFS;
        mem_wdata = flag_byte;
      end
      ST_POP1: begin
        mem_re = 1'b1;
        mem_addr = stack_pointer + PAIR_HI_OFS;
      end
      ST_POP2: begin
        mem_re = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // architectural registers
  // ---------------------------------------------------------------

  // accumulator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= ACC_RESET;
    end else if (arith_go && !to_mem) begin
      acc <= alu_out[7:0];
    end else if ((state == ST_OPER) && (op_q == OP_XCH)) begin
      acc <= mem_rdata;
    end else if (state == ST_POP1) begin
      acc <= mem_rdata;
    end
  end

  // stack pointer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer <= SP_RESET;
    end else if (op_fire && (op_code == OP_POP)) begin
      stack_pointer <= stack_pointer - SP_STEP;
    end else if (state == ST_PUSH2) begin
      stack_pointer <= stack_pointer + SP_STEP;
    end else if (sp_load && op_ready && !op_fire) begin
      stack_pointer <= sp_value;
    end
  end

  // flags: only arithmetic and restore touch them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag <= FLAG_RESET;
      carry_flag <= FLAG_RESET;
      half_carry_flag <= FLAG_RESET;
      signed_excess_flag <= FLAG_RESET;
    end else if (arith_go) begin
      zero_flag <= alu_out[8];
      carry_flag <= alu_out[9];
      half_carry_flag <= alu_out[10];
      signed_excess_flag <= alu_out[11];
    end else if (state == ST_POP2) begin
      zero_flag <= mem_rdata[FLAG_Z_BIT];
      carry_flag <= mem_rdata[FLAG_C_BIT];
      half_carry_flag <= mem_rdata[FLAG_AC_BIT];
      signed_excess_flag <= mem_rdata[FLAG_OV_BIT];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  a_store_two_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_STORE_IND) |=>
      (mem_we && op_done && mem_addr == mem_rdata && mem_wdata == acc))
    else $error("indirect store not written in its second cycle");

  a_store_flags_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_STORE_IND) |=> ##1
      ({zero_flag, carry_flag, half_carry_flag, signed_excess_flag} ==
       $past({zero_flag, carry_flag, half_carry_flag, signed_excess_flag}, 2)))
    else $error("indirect store changed a flag");

  a_xch_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_XCH) |=>
      (mem_we && mem_wdata == $past(acc)) ##1 (acc == $past(mem_rdata)))
    else $error("exchange did not swap");

  a_push_sp_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_PUSH) |=> ##1
      (stack_pointer == 8'($past(stack_pointer, 2) + SP_STEP)))
    else $error("save did not advance stack pointer by two");

  a_pop_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_POP) |=>
      (stack_pointer == 8'($past(stack_pointer) - SP_STEP)) ##2
      (carry_flag == $past(mem_rdata[FLAG_C_BIT])))
    else $error("restore sequence wrong");

  a_add_imm_sum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_ADD_AI) |=>
      (acc == 8'($past(acc) + $past(op_imm)) &&
       carry_flag == (({1'b0, $past(acc)} + {1'b0, $past(op_imm)}) > 9'h0ff)))
    else $error("add immediate result or carry wrong");

  a_sub_imm_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_SUB_AI) |=>
      (acc == 8'($past(acc) - $past(op_imm)) && carry_flag == ($past(acc) < $past(op_imm))))
    else $error("subtract immediate borrow wrong");

  a_half_carry_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_ADD_AI) |=>
      (half_carry_flag == (({1'b0, $past(acc[3:0])} + {1'b0, $past(op_imm[3:0])}) > 5'h0f)))
    else $error("half carry wrong");

  a_zero_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arith_go && !to_mem) |=> (zero_flag == (acc == 8'h00)))
    else $error("zero flag does not match result");

  a_ptr_area: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_STORE_IND) |-> (mem_re && mem_addr <= PTR_AREA_MASK))
    else $error("pointer read outside 0..31");

  a_ovf_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (op_fire && op_code == OP_ADD_AI) |=>
      (signed_excess_flag == (($past(acc[7]) == $past(op_imm[7])) && (acc[7] != $past(acc[7])))))
    else $error("signed excess flag wrong");

endmodule
`default_nettype wire
